// File: rtl/gfm_defs.svh
// Constants for the general-purpose pin function multiplexer
`ifndef GFM_DEFS_SVH
`define GFM_DEFS_SVH

`define GFM_FN_W            4
`define GFM_DIR_INPUT       1'b1
`define GFM_POL_HIGH        1'b1

`define GFM_IN_LVL_SHORT    4'h0
`define GFM_IN_LVL_MID      4'h1
`define GFM_IN_ONOFF        4'h2
`define GFM_IN_SLPWK_SHORT  4'h3
`define GFM_IN_SLPWK_LONG   4'h4
`define GFM_IN_SLEEP        4'h5
`define GFM_IN_ON           4'h6
`define GFM_IN_WDOG         4'h7
`define GFM_IN_DVS1         4'h8
`define GFM_IN_DVS2         4'h9
`define GFM_IN_HWEN1        4'hA
`define GFM_IN_HWEN2        4'hB
`define GFM_IN_HWC1_SHORT   4'hC
`define GFM_IN_HWC2_SHORT   4'hD
`define GFM_IN_HWC1_LONG    4'hE
`define GFM_IN_HWC2_LONG    4'hF

`define GFM_OUT_LVL         4'h0
`define GFM_OUT_OSC         4'h1
`define GFM_OUT_ON          4'h2
`define GFM_OUT_SLEEP       4'h3
`define GFM_OUT_PSC         4'h4
`define GFM_OUT_DVS1        4'h8
`define GFM_OUT_DVS2        4'h9
`define GFM_OUT_EXT_POWER_ENABLE_ONE        4'hA
`define GFM_OUT_EXT_POWER_ENABLE_TWO        4'hB
`define GFM_OUT_SUPOK       4'hC
`define GFM_OUT_GOOD        4'hD
`define GFM_OUT_EXTCLK      4'hE
`define GFM_OUT_AUXRST      4'hF

`define GFM_TICK_NS         30518
`define GFM_DB_SHORT_NS     32000
`define GFM_DB_MID_NS       4000000
`define GFM_DB_LONG_NS      32000000
`define GFM_DB_SHORT_TICKS  ((`GFM_DB_SHORT_NS + `GFM_TICK_NS - 1) / `GFM_TICK_NS)
`define GFM_DB_MID_TICKS    ((`GFM_DB_MID_NS + `GFM_TICK_NS - 1) / `GFM_TICK_NS)
`define GFM_DB_LONG_TICKS   ((`GFM_DB_LONG_NS + `GFM_TICK_NS - 1) / `GFM_TICK_NS)

`define GFM_SYS_CLK_HZ      40000000
`define GFM_EXTCLK_HZ       2000000
`define GFM_EXTCLK_HALF     (`GFM_SYS_CLK_HZ / (2 * `GFM_EXTCLK_HZ))

`endif

// File: rtl/gfm_pkg.sv
// Types for the general-purpose pin function multiplexer
package gfm_pkg;
    typedef logic [3:0] gfm_fn_t;
    typedef logic [10:0] gfm_cnt_t;
    typedef enum logic [1:0] {GFM_DB_NONE, GFM_DB_SHORT, GFM_DB_MID, GFM_DB_LONG} gfm_db_e;
endpackage

// File: rtl/gfm_gpio_mux.sv
// Per-pin input/output function multiplexer with debounce
`timescale 1ns/1ps
`include "gfm_defs.svh"

module gfm_gpio_mux
    import gfm_pkg::*;
#(
    parameter int NUM_PINS = 12
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  osc_32k,
    input  wire logic [NUM_PINS-1:0]   pin_in,
    output logic      [NUM_PINS-1:0]   pin_out,
    output logic      [NUM_PINS-1:0]   pin_oe,
    input  wire logic [NUM_PINS-1:0]   pin_direction_bit,
    input  wire logic [NUM_PINS*4-1:0] pin_function_select,
    input  wire logic [NUM_PINS-1:0]   pin_polarity_bit,
    input  wire logic [NUM_PINS-1:0]   pin_level_bit,
    output logic      [NUM_PINS-1:0]   pin_level_read,
    input  wire logic                  state_on,
    input  wire logic                  state_sleep,
    input  wire logic                  power_state_change_flag,
    input  wire logic [1:0]            dvs_done,
    input  wire logic                  ext_power_enable_one,
    input  wire logic                  ext_power_enable_two,
    input  wire logic                  supply_ok_signal,
    input  wire logic                  converters_good_status,
    input  wire logic                  aux_reset_sleep_value,
    output logic                       on_request,
    output logic                       off_request,
    output logic                       sleep_request,
    output logic                       wake_request,
    output logic                       watchdog_reset,
    output logic [1:0]                 dvs_select,
    output logic [1:0]                 hw_enable,
    output logic [1:0]                 hw_control
);

    if (NUM_PINS < 1 || NUM_PINS > 32) begin : g_bad_pins
        $error("NUM_PINS out of range");
    end
    if (`GFM_DB_LONG_TICKS >= (1 << $bits(gfm_cnt_t))) begin : g_bad_cnt
        $error("Debounce counter too narrow");
    end
    if (`GFM_EXTCLK_HALF < 1 || `GFM_EXTCLK_HALF > 16) begin : g_bad_div
        $error("Clock divider too narrow");
    end

    localparam gfm_cnt_t LIM_SHORT = gfm_cnt_t'(`GFM_DB_SHORT_TICKS);
    localparam gfm_cnt_t LIM_MID   = gfm_cnt_t'(`GFM_DB_MID_TICKS);
    localparam gfm_cnt_t LIM_LONG  = gfm_cnt_t'(`GFM_DB_LONG_TICKS);
    localparam logic [3:0] EXT_HALF = 4'(`GFM_EXTCLK_HALF - 1);
    // Pin watched by the input-side checks
    localparam int CP = (NUM_PINS > 2) ? 2 : 0;

    // Oscillator sampling, tick and 2MHz divider
    logic [2:0] osc_q, osc_d;
    logic [3:0] div_q, div_d;
    logic       clk2m_q, clk2m_d;
    logic       tick;

    always_comb begin
        osc_d   = {osc_q[1:0], osc_32k};
        div_d   = div_q + 4'h1;
        clk2m_d = clk2m_q;
        if (div_q == EXT_HALF) begin
            div_d   = 4'h0;
            clk2m_d = ~clk2m_q;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            osc_q   <= 3'h0;
            div_q   <= 4'h0;
            clk2m_q <= 1'b0;
        end else begin
            osc_q   <= osc_d;
            div_q   <= div_d;
            clk2m_q <= clk2m_d;
        end
    end

    assign tick = osc_q[1] & ~osc_q[2];

    logic            off_state;
    logic            aux_rst;
    logic [NUM_PINS-1:0] on_v, off_v, slp_v, wk_v, wd_v;
    logic [NUM_PINS-1:0] dvs1_v, dvs2_v, en1_v, en2_v, hc1_v, hc2_v;
    logic [NUM_PINS-1:0] lvl_v;

    assign off_state = ~state_on & ~state_sleep;
    assign aux_rst   = off_state | (state_sleep & aux_reset_sleep_value);

    genvar i;
    generate
        for (i = 0; i < NUM_PINS; i++) begin : g_pin
            logic [1:0] sync_q, sync_d;
            logic       db_q, db_d;
            gfm_cnt_t   cnt_q, cnt_d;
            logic       prev_q, prev_d;
            logic       out_q, out_d;
            logic       oe_q, oe_d;
            gfm_fn_t    fn;
            gfm_db_e    dsel;
            gfm_cnt_t   lim;
            logic       dir, pol, act, rise, fall, f;

            assign fn  = pin_function_select[i*`GFM_FN_W +: `GFM_FN_W];
            assign dir = pin_direction_bit[i] == `GFM_DIR_INPUT;
            assign pol = pin_polarity_bit[i] == `GFM_POL_HIGH;

            always_comb begin
                case (fn)
                    `GFM_IN_LVL_MID:                       dsel = GFM_DB_MID;
                    `GFM_IN_ONOFF, `GFM_IN_SLPWK_LONG,
                    `GFM_IN_HWC1_LONG, `GFM_IN_HWC2_LONG:  dsel = GFM_DB_LONG;
                    `GFM_IN_DVS1, `GFM_IN_DVS2:            dsel = GFM_DB_NONE;
                    default:                               dsel = GFM_DB_SHORT;
                endcase
                case (dsel)
                    GFM_DB_MID:  lim = LIM_MID;
                    GFM_DB_LONG: lim = LIM_LONG;
                    default:     lim = LIM_SHORT;
                endcase
            end

            assign act  = pol ? db_q : ~db_q;
            // Edges taken on the debounced level before polarity so reset and polarity changes make none
            assign rise = dir & (pol ? (db_q & ~prev_q) : (~db_q & prev_q));
            assign fall = dir & (pol ? (~db_q & prev_q) : (db_q & ~prev_q));

            always_comb begin
                sync_d = {sync_q[0], pin_in[i]};
                db_d   = db_q;
                cnt_d  = cnt_q;
                prev_d = db_q;
                if (!dir || dsel == GFM_DB_NONE) begin
                    db_d  = sync_q[1];
                    cnt_d = '0;
                end else if (sync_q[1] == db_q) begin
                    cnt_d = '0;
                end else if (tick) begin
                    if (cnt_q + gfm_cnt_t'(1) >= lim) begin
                        db_d  = sync_q[1];
                        cnt_d = '0;
                    end else begin
                        cnt_d = cnt_q + gfm_cnt_t'(1);
                    end
                end
                case (fn)
                    `GFM_OUT_LVL:    f = pin_level_bit[i];
                    `GFM_OUT_OSC:    f = osc_q[1];
                    `GFM_OUT_ON:     f = state_on;
                    `GFM_OUT_SLEEP:  f = state_sleep;
                    `GFM_OUT_PSC:    f = power_state_change_flag;
                    `GFM_OUT_DVS1:   f = dvs_done[0];
                    `GFM_OUT_DVS2:   f = dvs_done[1];
                    `GFM_OUT_EXT_POWER_ENABLE_ONE:   f = ext_power_enable_one;
                    `GFM_OUT_EXT_POWER_ENABLE_TWO:   f = ext_power_enable_two;
                    `GFM_OUT_SUPOK:  f = supply_ok_signal;
                    `GFM_OUT_GOOD:   f = converters_good_status & ~off_state;
                    `GFM_OUT_EXTCLK: f = clk2m_q & (ext_power_enable_one | ext_power_enable_two);
                    `GFM_OUT_AUXRST: f = aux_rst;
                    default:         f = 1'b0;
                endcase
                out_d = pol ? f : ~f;
                oe_d  = ~dir;
            end

            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    sync_q <= 2'h0;
                    db_q   <= 1'b0;
                    cnt_q  <= '0;
                    prev_q <= 1'b0;
                    out_q  <= 1'b0;
                    oe_q   <= 1'b0;
                end else begin
                    sync_q <= sync_d;
                    db_q   <= db_d;
                    cnt_q  <= cnt_d;
                    prev_q <= prev_d;
                    out_q  <= out_d;
                    oe_q   <= oe_d;
                end
            end

            assign pin_out[i] = out_q;
            assign pin_oe[i]  = oe_q;
            assign lvl_v[i]   = dir & (fn == `GFM_IN_LVL_SHORT || fn == `GFM_IN_LVL_MID) & act;
            assign on_v[i]    = (fn == `GFM_IN_ONOFF || fn == `GFM_IN_ON) & rise;
            assign off_v[i]   = (fn == `GFM_IN_ONOFF) & fall;
            assign slp_v[i]   = (fn == `GFM_IN_SLPWK_SHORT || fn == `GFM_IN_SLPWK_LONG
                                 || fn == `GFM_IN_SLEEP) & rise;
            assign wk_v[i]    = (fn == `GFM_IN_SLPWK_SHORT || fn == `GFM_IN_SLPWK_LONG) & fall;
            assign wd_v[i]    = dir & (fn == `GFM_IN_WDOG) & act;
            assign dvs1_v[i]  = dir & (fn == `GFM_IN_DVS1) & act;
            assign dvs2_v[i]  = dir & (fn == `GFM_IN_DVS2) & act;
            assign en1_v[i]   = dir & (fn == `GFM_IN_HWEN1) & act;
            assign en2_v[i]   = dir & (fn == `GFM_IN_HWEN2) & act;
            assign hc1_v[i]   = dir & (fn == `GFM_IN_HWC1_SHORT || fn == `GFM_IN_HWC1_LONG) & act;
            assign hc2_v[i]   = dir & (fn == `GFM_IN_HWC2_SHORT || fn == `GFM_IN_HWC2_LONG) & act;
        end
    endgenerate

    // Registered system-side results
    logic [NUM_PINS-1:0] lvl_q, lvl_d;
    logic [10:0]         evt_q, evt_d;

    always_comb begin
        lvl_d = lvl_v;
        evt_d = {|on_v, |off_v, |slp_v, |wk_v, |wd_v, |dvs2_v, |dvs1_v,
                 |en2_v, |en1_v, |hc2_v, |hc1_v};
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lvl_q <= '0;
            evt_q <= 11'h000;
        end else begin
            lvl_q <= lvl_d;
            evt_q <= evt_d;
        end
    end

    assign pin_level_read = lvl_q;
    assign on_request     = evt_q[10];
    assign off_request    = evt_q[9];
    assign sleep_request  = evt_q[8];
    assign wake_request   = evt_q[7];
    assign watchdog_reset = evt_q[6];
    assign dvs_select     = evt_q[5:4];
    assign hw_enable      = evt_q[3:2];
    assign hw_control     = evt_q[1:0];

    // Output checks on pin 0, input checks on pin CP
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    dir_oe_a: assert property (##1 pin_oe[0] == !$past(pin_direction_bit[0]))
        else $error("pin enable does not follow direction");
    out_level_a: assert property ((!pin_direction_bit[0] && g_pin[0].fn == `GFM_OUT_LVL)
        |=> pin_out[0] == ($past(pin_polarity_bit[0]) ~^ $past(pin_level_bit[0])))
        else $error("level output wrong");
    out_on_a: assert property ((!pin_direction_bit[0] && g_pin[0].fn == `GFM_OUT_ON
        && pin_polarity_bit[0]) |=> pin_out[0] == $past(state_on))
        else $error("on indicator wrong");
    aux_off_a: assert property ((!pin_direction_bit[0] && g_pin[0].fn == `GFM_OUT_AUXRST
        && !state_on && !state_sleep) |=> pin_out[0] == $past(pin_polarity_bit[0]))
        else $error("aux reset not asserted in off");
    good_off_a: assert property ((!pin_direction_bit[0] && g_pin[0].fn == `GFM_OUT_GOOD
        && pin_polarity_bit[0] && !state_on && !state_sleep) |=> !pin_out[0])
        else $error("good shown outside on or sleep");
    extclk_gate_a: assert property ((!pin_direction_bit[0] && g_pin[0].fn == `GFM_OUT_EXTCLK
        && pin_polarity_bit[0] && !ext_power_enable_one && !ext_power_enable_two) |=> !pin_out[0])
        else $error("external clock runs while disabled");
    dvs_nodb_a: assert property ((pin_direction_bit[CP] && g_pin[CP].fn == `GFM_IN_DVS1)
        |=> g_pin[CP].db_q == $past(g_pin[CP].sync_q[1]))
        else $error("voltage select is debounced");
    db_tick_a: assert property ((pin_direction_bit[CP] && g_pin[CP].fn == `GFM_IN_LVL_SHORT && !tick)
        |=> $stable(g_pin[CP].db_q))
        else $error("debounced level moved without tick");
    lvl_read_a: assert property ((pin_direction_bit[CP] && g_pin[CP].fn == `GFM_IN_LVL_MID)
        |=> pin_level_read[CP] == ($past(pin_polarity_bit[CP]) ~^ $past(g_pin[CP].db_q)))
        else $error("level read wrong");
    on_req_a: assert property ((g_pin[CP].fn == `GFM_IN_ONOFF && g_pin[CP].rise) |=> on_request)
        else $error("on request missing");
    off_req_a: assert property ((g_pin[CP].fn == `GFM_IN_ONOFF && g_pin[CP].fall) |=> off_request)
        else $error("off request missing");
    sleep_req_a: assert property ((g_pin[CP].fn == `GFM_IN_SLEEP && g_pin[CP].rise) |=> sleep_request)
        else $error("sleep request missing");

    on_req_c: cover property (on_request);
    off_req_c: cover property (off_request);
    sleep_req_c: cover property (sleep_request);
    wake_req_c: cover property (wake_request);

endmodule // gfm_gpio_mux

// File: test/gfm_pad_model.sv
// Far-side model: pad wires and a free-running 4 MHz stand-in for the 32 kHz oscillator
`timescale 1ns/1ps
module gfm_pad_model #(
    parameter int  NUM_PINS    = 12,
    parameter real OSC_HALF_NS = 125.0
) (
    input  wire logic [NUM_PINS-1:0] pin_out,
    input  wire logic [NUM_PINS-1:0] pin_oe,
    input  wire logic [NUM_PINS-1:0] pin_drive,
    output logic      [NUM_PINS-1:0] pin_in,
    output logic                     osc_32k
);
    // Sped-up oscillator so the long debounce counts fit the run
    always begin
        osc_32k = 1'b0;
        #(OSC_HALF_NS);
        osc_32k = 1'b1;
        #(OSC_HALF_NS);
    end
    // Pin level: the device wins while it drives, else the outside source
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_drive);
endmodule // gfm_pad_model

// File: test/testbench.sv
// Self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
module testbench;
    import gfm_pkg::*;
    localparam int TK = 10;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        osc_32k;
    logic [11:0] pin_in, pin_out, pin_oe, pin_level_read, drv = '0;
    logic [11:0] dir = 12'hFFF, pol = 12'hFFF, lvl = '0;
    logic [47:0] fn = '0;
    logic [9:0]  sys = '0;
    logic        on_request, off_request, sleep_request, wake_request, watchdog_reset;
    logic [1:0]  dvs_select, hw_enable, hw_control;
    int          req_n[4] = '{0, 0, 0, 0};
    int          mismatches = 0;
    int          compares = 0;

    always #12.5 clk = ~clk;

    gfm_pad_model gfm_pad_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .pin_drive(drv), .pin_in(pin_in),
        .osc_32k(osc_32k));
    gfm_gpio_mux gfm_gpio_mux_inst (.clk(clk), .sys_rst(sys_rst), .osc_32k(osc_32k), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_direction_bit(dir), .pin_function_select(fn),
        .pin_polarity_bit(pol), .pin_level_bit(lvl), .pin_level_read(pin_level_read), .state_on(sys[9]),
        .state_sleep(sys[8]), .power_state_change_flag(sys[7]), .dvs_done(sys[6:5]),
        .ext_power_enable_one(sys[4]), .ext_power_enable_two(sys[3]), .supply_ok_signal(sys[2]),
        .converters_good_status(sys[1]), .aux_reset_sleep_value(sys[0]), .on_request(on_request),
        .off_request(off_request), .sleep_request(sleep_request), .wake_request(wake_request),
        .watchdog_reset(watchdog_reset), .dvs_select(dvs_select), .hw_enable(hw_enable),
        .hw_control(hw_control));

    // Request pulse counters: on, off, sleep, wake
    always @(negedge clk) begin
        if (on_request === 1'b1) req_n[0]++;
        if (off_request === 1'b1) req_n[1]++;
        if (sleep_request === 1'b1) req_n[2]++;
        if (wake_request === 1'b1) req_n[3]++;
    end

    function automatic int tot();
        return req_n[0] + req_n[1] + req_n[2] + req_n[3];
    endfunction

    task automatic chk(input string n, input logic e, input logic s);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %b seen %b", n, e, s);
        end
    endtask

    task automatic setp(input int p, input logic d, input logic [3:0] f, input logic po);
        dir[p] = d;
        fn[p*4 +: 4] = f;
        pol[p] = po;
        repeat (4) @(negedge clk);
    endtask

    function automatic logic oexp(input logic [3:0] f, input logic p);
        logic v;
        case (f)
            4'h0: v = lvl[0];
            4'h2: v = sys[9];
            4'h3: v = sys[8];
            4'h4: v = sys[7];
            4'h8: v = sys[5];
            4'h9: v = sys[6];
            4'hA: v = sys[4];
            4'hB: v = sys[3];
            4'hC: v = sys[2];
            4'hD: v = sys[1] & (sys[9] | sys[8]);
            4'hF: v = ~sys[9] & (~sys[8] | sys[0]);
            default: v = 1'b0;
        endcase
        return p ? v : ~v;
    endfunction

    function automatic logic seen(input logic [3:0] f);
        case (f)
            4'h0, 4'h1: return pin_level_read[2];
            4'h7: return watchdog_reset;
            4'hA: return hw_enable[0];
            4'hB: return hw_enable[1];
            4'hC, 4'hE: return hw_control[0];
            default: return hw_control[1];
        endcase
    endfunction

    // Output table on pin 0 under four system states, both polarities
    task automatic out_table();
        logic [9:0] pat[4] = '{10'h2B6, 10'h14B, 10'h0E5, 10'h15A};
        for (int s = 0; s < 4; s++) begin
            sys = pat[s];
            lvl[0] = pat[s][0];
            for (int f = 0; f < 16; f++) begin
                if (f == 1 || f == 14) continue;
                for (int p = 0; p < 2; p++) begin
                    setp(0, 1'b0, 4'(f), 1'(p));
                    chk("pin_out", oexp(4'(f), 1'(p)), pin_out[0]);
                    chk("pin_oe", 1'b1, pin_oe[0]);
                    chk("pin_oe_in", 1'b0, pin_oe[1]);
                end
            end
        end
    endtask

    task automatic clk_test(input logic [3:0] f, input logic [9:0] s, input logic e);
        int   n;
        logic pv;
        n = 0;
        sys = s;
        setp(0, 1'b0, f, 1'b1);
        pv = pin_out[0];
        for (int i = 0; i < 100; i++) begin
            @(negedge clk);
            if (pin_out[0] !== pv) n++;
            pv = pin_out[0];
        end
        chk("clk_toggles", e, n > 0);
    endtask

    // Drive pin 2 and check the debounce window; idx -1 level, -2 ignored, else request counter
    task automatic db_edge(input logic [3:0] f, input int n, input logic lv, input int idx);
        int t0;
        int s0;
        t0 = tot();
        s0 = (idx < 0) ? 0 : req_n[idx];
        drv[2] = lv;
        repeat ((n - 1) * TK - 2) @(negedge clk);
        if (idx == -1) chk("level_early", ~lv, seen(f));
        chk("req_early", 1'b1, tot() == t0);
        repeat (2 * TK + 20) @(negedge clk);
        if (idx == -1) chk("level_late", lv, seen(f));
        if (idx >= 0) chk("req_late", 1'b1, req_n[idx] == s0 + 1);
        chk("req_total", 1'b1, tot() == t0 + ((idx >= 0) ? 1 : 0));
    endtask

    task automatic in_levels();
        logic [3:0] c[9] = '{4'h0, 4'h1, 4'h7, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
        int         l[9] = '{2, 132, 2, 2, 2, 2, 2, 1049, 1049};
        for (int i = 0; i < 9; i++) begin
            setp(2, 1'b1, c[i], 1'b1);
            db_edge(c[i], l[i], 1'b1, -1);
            if (i == 0) begin
                setp(2, 1'b1, 4'h0, 1'b0);
                chk("level_inverted", 1'b0, pin_level_read[2]);
                chk("level_other", 1'b0, pin_level_read[0]);
                setp(2, 1'b1, 4'h0, 1'b1);
            end
            db_edge(c[i], l[i], 1'b0, -1);
        end
    endtask

    task automatic in_requests();
        logic [3:0] c[10] = '{4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h4, 4'h5, 4'h5, 4'h6, 4'h6};
        int         x[10] = '{0, 1, 2, 3, 2, 3, 2, -2, 0, -2};
        for (int i = 0; i < 10; i++) begin
            if (i % 2 == 0) setp(2, 1'b1, c[i], 1'b1);
            db_edge(c[i], (c[i] == 4'h2 || c[i] == 4'h4) ? 1049 : 2, i % 2 == 0, x[i]);
        end
    endtask

    task automatic in_dvs();
        for (int k = 0; k < 2; k++) begin
            setp(2, 1'b1, 4'(8 + k), 1'b1);
            drv[2] = 1'b1;
            repeat (2) @(negedge clk);
            chk("dvs_early", 1'b0, dvs_select[k]);
            repeat (3) @(negedge clk);
            chk("dvs_late", 1'b1, dvs_select[k]);
            drv[2] = 1'b0;
            repeat (6) @(negedge clk);
        end
    endtask

    task automatic wrap_up();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (20) @(negedge clk);
        chk("pin_oe_reset", 1'b0, pin_oe[0]);
        chk("pin_out_reset", 1'b0, pin_out[0]);
        sys_rst = 1'b0;
        repeat (2) @(negedge clk);
        out_table();
        clk_test(4'h1, 10'h000, 1'b1);
        clk_test(4'hE, 10'h000, 1'b0);
        clk_test(4'hE, 10'h010, 1'b1);
        clk_test(4'hE, 10'h008, 1'b1);
        in_dvs();
        in_levels();
        in_requests();
        wrap_up();
    end

    initial begin
        repeat (95000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
endmodule // testbench
